// File: design/timer3_capture_top.sv
// Timer 3 capture readout with Wishbone register access
// What this block does
// - Modes 1 and 4 read live counter
// - Capture modes store counter on event
// - Events: input pin edge or timer 2
// - Two reads: high nibble, then low
// - Capture register read-only at B/4
//
// Added by the designer: the address map and register access over Wishbone.
`timescale 1ns/10ps
module timer3_capture_top
  import t3cap_pkg::*;
(
  input wire logic I_CLK,
  input wire logic I_NRST,
  input wire logic I_WB_CYC,
  input wire logic I_WB_STB,
  input wire logic I_WB_WE,
  input wire logic [ADR_W-1:0] I_WB_ADR,
  input wire logic [3:0] I_WB_SEL,
  input wire logic [DAT_W-1:0] I_WB_DAT,
  input wire logic [7:0] I_COUNT,
  input wire logic I_T3_PIN,
  input wire logic I_T2_TRIG,
  output logic [DAT_W-1:0] O_WB_DAT,
  output logic O_WB_ACK
);
  // ***************************************************
  // Declarations
  // ***************************************************
  logic take;
  logic hit_cap;
  logic hit_ctrl;
  logic hit_stat;
  logic [3:0] mode_reg;
  logic [1:0] edge_reg;
  logic pin_en_reg;
  logic trig_en_reg;
  logic phase_reg;
  logic [7:0] snap_reg;
  logic [7:0] snap_next;
  logic [7:0] src_byte;
  logic [7:0] cap_value;
  logic cap_valid;
  logic raw_event;
  logic cap_event;
  logic [DAT_W-1:0] rd_next;

  // ***************************************************
  // Bus decode
  // ***************************************************
  // Ack is registered: one request per two cycles at most, by design
  assign take = I_WB_CYC & I_WB_STB & ~O_WB_ACK;
  assign hit_cap = adr_hit(I_WB_ADR, CAP_ADDR);
  assign hit_ctrl = adr_hit(I_WB_ADR, CTRL_ADDR);
  assign hit_stat = adr_hit(I_WB_ADR, STAT_ADDR);

  // ***************************************************
  // Capture path
  // ***************************************************
  t3cap_event u_event (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_pin(I_T3_PIN),
    .i_edge_sel(edge_reg),
    .i_pin_en(pin_en_reg),
    .i_trig(I_T2_TRIG),
    .i_trig_en(trig_en_reg),
    .o_event(raw_event)
  );

  // Events outside the capture modes are dropped
  assign cap_event = raw_event & is_capture(mode_reg);

  t3cap_latch u_latch (
    .i_clk(I_CLK),
    .i_nrst(I_NRST),
    .i_event(cap_event),
    .i_count(I_COUNT),
    .o_value(cap_value),
    .o_valid(cap_valid)
  );

  assign src_byte = is_direct(mode_reg) ? I_COUNT : cap_value;

  // ***************************************************
  // Control register
  // ***************************************************
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      mode_reg <= MODE_RESET;
      edge_reg <= EDGE_RESET;
      pin_en_reg <= 1'b0;
      trig_en_reg <= 1'b0;
    end else if (take && I_WB_WE && hit_ctrl && I_WB_SEL[0]) begin
      mode_reg <= I_WB_DAT[CTRL_MODE_LSB +: 4];
      edge_reg <= I_WB_DAT[CTRL_EDGE_LSB +: 2];
      pin_en_reg <= I_WB_DAT[CTRL_PIN_EN_BIT];
      trig_en_reg <= I_WB_DAT[CTRL_TRIG_EN_BIT];
    end
  end

  // ***************************************************
  // Nibble read sequencing
  // ***************************************************
  // Whole byte is frozen on the first read; live counter may move between reads
  always_comb begin
    snap_next = snap_reg;
    if (take && !I_WB_WE && hit_cap && !phase_reg) begin
      snap_next = src_byte;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      snap_reg <= CAP_RESET;
    end else begin
      snap_reg <= snap_next;
    end
  end

  // Writing 1 to the phase bit of status restarts the pair
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      phase_reg <= 1'b0;
    end else if (take && !I_WB_WE && hit_cap) begin
      phase_reg <= ~phase_reg;
    end else if (take && I_WB_WE && hit_stat && I_WB_SEL[0] && I_WB_DAT[STAT_PHASE_BIT]) begin
      phase_reg <= 1'b0;
    end
  end

  // ***************************************************
  // Read data and acknowledge
  // ***************************************************
  always_comb begin
    rd_next = '0;
    if (hit_cap) begin
      rd_next[3:0] = phase_reg ? snap_reg[3:0] : src_byte[7:4];
    end else if (hit_ctrl) begin
      rd_next[CTRL_MODE_LSB +: 4] = mode_reg;
      rd_next[CTRL_EDGE_LSB +: 2] = edge_reg;
      rd_next[CTRL_PIN_EN_BIT] = pin_en_reg;
      rd_next[CTRL_TRIG_EN_BIT] = trig_en_reg;
    end else if (hit_stat) begin
      rd_next[STAT_PHASE_BIT] = phase_reg;
      rd_next[STAT_VALID_BIT] = cap_valid;
    end
  end

  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WB_DAT <= '0;
    end else if (take && !I_WB_WE) begin
      O_WB_DAT <= rd_next;
    end
  end

  // Unmapped addresses are acked too so a stray access never hangs
  always_ff @(posedge I_CLK or negedge I_NRST) begin
    if (!I_NRST) begin
      O_WB_ACK <= 1'b0;
    end else begin
      O_WB_ACK <= take;
    end
  end

  // ***************************************************
  // Checks
  // ***************************************************
  a_ack_next_cycle: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (I_WB_CYC && I_WB_STB && !O_WB_ACK) |=> O_WB_ACK ##1 !O_WB_ACK)
    else $error("bus ack not given exactly one cycle after request");

  a_first_nibble: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap && !phase_reg) |=>
      (O_WB_DAT == {28'h0, $past(src_byte[7:4])}) && phase_reg)
    else $error("first capture read did not return the high nibble");

  a_second_nibble: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap && phase_reg) |=>
      (O_WB_DAT == {28'h0, $past(snap_reg[3:0])}) && !phase_reg)
    else $error("second capture read did not return the low nibble");

  a_direct_live: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap && !phase_reg && is_direct(mode_reg)) |=>
      (snap_reg == $past(I_COUNT)))
    else $error("direct mode read did not take the live counter");

  a_capture_mode_read: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap && !phase_reg && is_capture(mode_reg)) |=>
      (snap_reg == $past(cap_value)))
    else $error("capture mode read did not return the stored value");

  a_snap_stable: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (phase_reg && !(take && hit_cap)) |=> $stable(snap_reg))
    else $error("snapshot changed between the two nibble reads");

  a_read_only: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && I_WB_WE && hit_cap) |=> $stable(phase_reg) && $stable(mode_reg))
    else $error("write to the capture register had an effect");

  a_event_gated: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (raw_event && !is_capture(mode_reg)) |=> $stable(cap_value))
    else $error("capture value changed outside capture modes");

  // ***************************************************
  // Checks on the bus handshake
  // ***************************************************
  a_ack_needs_req: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_WB_ACK |-> $past(take))
    else $error("bus ack without a taken request");

  a_ack_single: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    O_WB_ACK |=> !O_WB_ACK)
    else $error("bus ack held longer than one cycle");

  a_ack_idle_low: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(I_WB_CYC && I_WB_STB) |=> !O_WB_ACK)
    else $error("bus ack with no request pending");

  a_rdat_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(take && !I_WB_WE) |=> $stable(O_WB_DAT))
    else $error("read data changed without a read");

  a_unmapped_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && !hit_cap && !hit_ctrl && !hit_stat) |=>
      (O_WB_DAT == '0))
    else $error("unmapped read returned nonzero data");

  // ***************************************************
  // Checks on the control and status registers
  // ***************************************************
  a_ctrl_write: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && I_WB_WE && hit_ctrl && I_WB_SEL[0]) |=>
      (mode_reg == 4'($past(I_WB_DAT) >> CTRL_MODE_LSB)) &&
      (edge_reg == 2'($past(I_WB_DAT) >> CTRL_EDGE_LSB)) &&
      (pin_en_reg == 1'($past(I_WB_DAT) >> CTRL_PIN_EN_BIT)) &&
      (trig_en_reg == 1'($past(I_WB_DAT) >> CTRL_TRIG_EN_BIT)))
    else $error("control write did not land");

  a_ctrl_sel_gate: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && I_WB_WE && hit_ctrl && !I_WB_SEL[0]) |=>
      $stable(mode_reg) && $stable(edge_reg) && $stable(pin_en_reg) && $stable(trig_en_reg))
    else $error("control changed by a write without byte select");

  a_ctrl_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(take && I_WB_WE && hit_ctrl) |=>
      $stable(mode_reg) && $stable(edge_reg) && $stable(pin_en_reg) && $stable(trig_en_reg))
    else $error("control changed without a control write");

  a_ctrl_readback: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_ctrl) |=>
      (O_WB_DAT == {24'h0, $past(trig_en_reg), $past(pin_en_reg), $past(edge_reg), $past(mode_reg)}))
    else $error("control read returned wrong fields");

  a_stat_readback: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_stat) |=>
      (O_WB_DAT[STAT_PHASE_BIT] == $past(phase_reg)) && (O_WB_DAT[STAT_VALID_BIT] == $past(cap_valid)))
    else $error("status read returned wrong flags");

  a_phase_restart: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && I_WB_WE && hit_stat && I_WB_SEL[0] && I_WB_DAT[STAT_PHASE_BIT]) |=> !phase_reg)
    else $error("status write did not restart the nibble pair");

  a_phase_hold: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(take && (hit_cap || hit_stat)) |=> $stable(phase_reg))
    else $error("nibble phase moved without a capture or status access");

  // ***************************************************
  // Checks on the capture readout
  // ***************************************************
  a_capture_store: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (raw_event && is_capture(mode_reg)) |=> (cap_value == $past(I_COUNT)))
    else $error("capture event in a capture mode stored no count");

  a_direct_no_store: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    is_direct(mode_reg) |=> $stable(cap_value))
    else $error("capture value changed in a direct mode");

  a_trig_raises_event: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (trig_en_reg && I_T2_TRIG) |=> raw_event)
    else $error("enabled timer 2 trigger raised no event");

  a_event_needs_source: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    raw_event |-> ($past(pin_en_reg) || $past(trig_en_reg)))
    else $error("capture event with no source enabled");

  a_valid_on_event: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    cap_event |=> cap_valid)
    else $error("capture event did not set the valid flag");

  a_valid_sticky: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    cap_valid |=> cap_valid)
    else $error("capture valid flag dropped");

  a_snap_first_only: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    !(take && !I_WB_WE && hit_cap && !phase_reg) |=> $stable(snap_reg))
    else $error("snapshot moved without a first nibble read");

  a_cap_upper_zero: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap) |=> (O_WB_DAT[DAT_W-1:4] == '0))
    else $error("capture read drove bits above the nibble");

  a_direct_high_nibble: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap && !phase_reg && is_direct(mode_reg)) |=>
      (O_WB_DAT[3:0] == 4'($past(I_COUNT) >> 4)))
    else $error("direct mode first read did not give the live high nibble");

  a_capture_high_nibble: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && !I_WB_WE && hit_cap && !phase_reg && is_capture(mode_reg)) |=>
      (O_WB_DAT[3:0] == 4'($past(cap_value) >> 4)))
    else $error("capture mode first read did not give the stored high nibble");

  a_cap_write_ignored: assert property (@(posedge I_CLK) disable iff (!I_NRST)
    (take && I_WB_WE && hit_cap) |=> $stable(snap_reg))
    else $error("write to the capture register moved the snapshot");
endmodule : timer3_capture_top

// File: design/t3cap_pkg.sv
// Constants and types shared by the timer 3 capture readout block
package t3cap_pkg;
  // ***************************************************
  // Address map
  // ***************************************************
  localparam int ADR_W = 12;
  localparam int DAT_W = 32;
  localparam logic [3:0] CAP_MAIN = 4'hb;
  localparam logic [3:0] CAP_SUB = 4'h4;
  localparam logic [7:0] CAP_INDEX = {CAP_MAIN, CAP_SUB};
  localparam logic [ADR_W-1:0] CAP_ADDR = {2'h0, CAP_INDEX, 2'h0};
  localparam logic [ADR_W-1:0] CTRL_ADDR = 12'h300;
  localparam logic [ADR_W-1:0] STAT_ADDR = 12'h304;

  // ***************************************************
  // Control and status register fields and reset values
  // ***************************************************
  localparam int CTRL_MODE_LSB = 0;
  localparam int CTRL_EDGE_LSB = 4;
  localparam int CTRL_PIN_EN_BIT = 6;
  localparam int CTRL_TRIG_EN_BIT = 7;
  localparam logic [3:0] MODE_RESET = 4'h0;
  localparam logic [1:0] EDGE_RESET = 2'h0;
  localparam int STAT_PHASE_BIT = 0;
  localparam int STAT_VALID_BIT = 1;
  localparam logic [7:0] CAP_RESET = 8'h00;

  // ***************************************************
  // Timer modes and capture edge choice
  // ***************************************************
  localparam logic [3:0] MODE_DIRECT_A = 4'h1;
  localparam logic [3:0] MODE_DIRECT_B = 4'h4;
  localparam logic [3:0] MODE_CAP_A = 4'h2;
  localparam logic [3:0] MODE_CAP_B = 4'h3;
  localparam logic [3:0] MODE_CAP_C = 4'h5;
  localparam logic [3:0] MODE_CAP_D = 4'hc;

  typedef enum logic [1:0] {
    EDGE_RISE,
    EDGE_FALL,
    EDGE_BOTH,
    EDGE_NONE
  } edge_sel_t;

  function automatic logic is_direct(input logic [3:0] mode);
    return (mode == MODE_DIRECT_A) || (mode == MODE_DIRECT_B);
  endfunction : is_direct

  function automatic logic is_capture(input logic [3:0] mode);
    return (mode == MODE_CAP_A) || (mode == MODE_CAP_B) || (mode == MODE_CAP_C) || (mode == MODE_CAP_D);
  endfunction : is_capture

  function automatic logic adr_hit(input logic [ADR_W-1:0] adr, input logic [ADR_W-1:0] target);
    return adr[ADR_W-1:2] == target[ADR_W-1:2];
  endfunction : adr_hit
endpackage : t3cap_pkg

// File: design/t3cap_event.sv
// Capture event source: timer input pin edge or second timer trigger
`timescale 1ns/10ps
module t3cap_event
  import t3cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_pin,
  input wire logic [1:0] i_edge_sel,
  input wire logic i_pin_en,
  input wire logic i_trig,
  input wire logic i_trig_en,
  output logic o_event
);
  logic pin_prev_reg;
  logic rise;
  logic fall;
  logic pin_hit;

  assign rise = i_pin & ~pin_prev_reg;
  assign fall = ~i_pin & pin_prev_reg;

  always_comb begin
    case (edge_sel_t'(i_edge_sel))
      EDGE_RISE: pin_hit = rise;
      EDGE_FALL: pin_hit = fall;
      EDGE_BOTH: pin_hit = rise | fall;
      default: pin_hit = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      pin_prev_reg <= 1'b0;
    end else begin
      pin_prev_reg <= i_pin;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_event <= 1'b0;
    end else begin
      o_event <= (i_pin_en & pin_hit) | (i_trig_en & i_trig);
    end
  end

  a_pin_edge_event: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_pin_en && i_edge_sel == 2'h0 && i_pin && !pin_prev_reg) |=> o_event)
    else $error("pin rising edge gave no capture event");

  a_trig_event: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (i_trig_en && i_trig) |=> o_event)
    else $error("second timer trigger gave no capture event");

  a_no_spurious_event: assert property (@(posedge i_clk) disable iff (!i_nrst)
    (!i_pin_en && !i_trig_en) |=> !o_event)
    else $error("capture event with both sources off");
endmodule : t3cap_event

// File: design/t3cap_latch.sv
// Capture register: holds the counter value caught at a capture event
`timescale 1ns/10ps
module t3cap_latch
  import t3cap_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_nrst,
  input wire logic i_event,
  input wire logic [7:0] i_count,
  output logic [7:0] o_value,
  output logic o_valid
);
  // Value is held between events so a split nibble read stays coherent
  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_value <= CAP_RESET;
    end else if (i_event) begin
      o_value <= i_count;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_valid <= 1'b0;
    end else if (i_event) begin
      o_valid <= 1'b1;
    end
  end

  a_capture_load: assert property (@(posedge i_clk) disable iff (!i_nrst)
    i_event |=> (o_value == $past(i_count)) && o_valid)
    else $error("capture event did not store the counter value");

  a_capture_hold: assert property (@(posedge i_clk) disable iff (!i_nrst)
    !i_event |=> $stable(o_value))
    else $error("captured value changed without an event");
endmodule : t3cap_latch

// File: sim/timer3_capture_readout_tb.sv
// Self-checking bench for the timer 3 capture readout block
`timescale 1ns/10ps
module timer3_capture_readout_tb;
  import t3cap_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [ADR_W-1:0] adr = '0;
  logic [3:0] sel = 4'h0;
  logic [DAT_W-1:0] wdat = '0;
  logic [7:0] cnt = 8'h00;
  logic pin = 1'b0;
  logic trig = 1'b0;
  logic [DAT_W-1:0] rdat;
  logic ack;
  int fail_count = 0;
  int n_compared = 0;
  logic [7:0] last = 8'h00;
  logic [3:0] wsel = 4'hf;

  timer3_capture_top dut (
    .I_CLK(clk), .I_NRST(nrst), .I_WB_CYC(cyc), .I_WB_STB(stb), .I_WB_WE(we), .I_WB_ADR(adr),
    .I_WB_SEL(sel), .I_WB_DAT(wdat), .I_COUNT(cnt), .I_T3_PIN(pin), .I_T2_TRIG(trig),
    .O_WB_DAT(rdat), .O_WB_ACK(ack)
  );

  initial begin
    forever #5 clk = ~clk;
  end

  // ***************************************************
  // Checking and closing
  // ***************************************************
  task automatic chk(input string name, input logic [DAT_W-1:0] seen, input logic [DAT_W-1:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : test_done

  function automatic logic [DAT_W-1:0] nib(input logic [7:0] v, input logic hi);
    return hi ? {28'h0, v[7:4]} : {28'h0, v[3:0]};
  endfunction : nib

  // ***************************************************
  // Bus cycles
  // ***************************************************
  // Waits for ack with a bound; one idle cycle follows every transfer
  task automatic wb(input logic w, input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d,
                    output logic [DAT_W-1:0] q);
    int n;
    n = 0;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= wsel;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 20);
    q = rdat;
    if (n >= 20) begin
      chk("ack wait", 32'h0, 32'h1);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask : wb

  task automatic rd_pair(input logic [7:0] v);
    logic [DAT_W-1:0] q;
    wb(1'b0, CAP_ADDR, '0, q);
    chk("capture high nibble", q, nib(v, 1'b1));
    wb(1'b0, CAP_ADDR, '0, q);
    chk("capture low nibble", q, nib(v, 1'b0));
  endtask : rd_pair

  // One event from pin or timer 2; count held steady around it
  task automatic cap_try(input logic [3:0] m, input logic [1:0] ed, input logic use_pin, input logic stores);
    logic [7:0] v;
    logic [DAT_W-1:0] q;
    v = 8'($urandom);
    wb(1'b1, CTRL_ADDR, {24'h0, !use_pin, use_pin, ed, m}, q);
    cnt <= v;
    repeat (2) @(posedge clk);
    if (use_pin) begin
      pin <= ~pin;
    end else begin
      trig <= 1'b1;
    end
    @(posedge clk);
    trig <= 1'b0;
    repeat (4) @(posedge clk);
    cnt <= ~v;
    if (stores) begin
      last = v;
    end
    rd_pair(last);
  endtask : cap_try

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end

  // ***************************************************
  // Scenarios
  // ***************************************************
  initial begin
    logic [DAT_W-1:0] q;
    logic [7:0] v;
    void'($urandom(33361));
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    wb(1'b0, STAT_ADDR, '0, q);
    chk("status after reset", q, 32'h0);
    wb(1'b0, CTRL_ADDR, '0, q);
    chk("control after reset", q, 32'h0);
    // Live count in direct modes; second nibble from the same snapshot
    for (int i = 0; i < 6; i++) begin
      v = 8'($urandom);
      wb(1'b1, CTRL_ADDR, {28'h0, (i % 2) ? MODE_DIRECT_B : MODE_DIRECT_A}, q);
      cnt <= v;
      wb(1'b0, CAP_ADDR, '0, q);
      chk("direct high nibble", q, nib(v, 1'b1));
      cnt <= ~v;
      wb(1'b0, CAP_ADDR, '0, q);
      chk("direct low nibble", q, nib(v, 1'b0));
    end
    cap_try(MODE_CAP_A, EDGE_RISE, 1'b1, 1'b1);
    cap_try(MODE_CAP_B, EDGE_FALL, 1'b1, 1'b1);
    cap_try(MODE_CAP_C, EDGE_BOTH, 1'b1, 1'b1);
    cap_try(MODE_CAP_D, EDGE_NONE, 1'b1, 1'b0);
    cap_try(MODE_CAP_B, EDGE_FALL, 1'b1, 1'b0);
    cap_try(MODE_CAP_D, EDGE_RISE, 1'b0, 1'b1);
    cap_try(MODE_RESET, EDGE_RISE, 1'b0, 1'b0);
    for (int i = 0; i < 8; i++) begin
      cap_try(($urandom % 2) ? MODE_CAP_C : MODE_CAP_A, EDGE_RISE, 1'b0, 1'b1);
    end
    wb(1'b0, STAT_ADDR, '0, q);
    chk("capture valid", q, 32'h2);
    // Odd read leaves phase set; a restart returns to the high nibble
    wb(1'b0, CAP_ADDR, '0, q);
    chk("lone high nibble", q, nib(last, 1'b1));
    wb(1'b0, STAT_ADDR, '0, q);
    chk("phase after one read", q, 32'h3);
    wb(1'b1, STAT_ADDR, 32'h0, q);
    wb(1'b0, STAT_ADDR, '0, q);
    chk("phase kept by zero write", q, 32'h3);
    wb(1'b1, STAT_ADDR, 32'h1, q);
    rd_pair(last);
    // Read-only capture register and an unmapped place
    wb(1'b1, CAP_ADDR, 32'hff, q);
    rd_pair(last);
    wb(1'b0, 12'h100, '0, q);
    chk("unmapped read", q, 32'h0);
    // Control read back; a write with byte select zero is ignored
    v = 8'($urandom);
    wb(1'b1, CTRL_ADDR, {24'h0, v}, q);
    wb(1'b0, CTRL_ADDR, '0, q);
    chk("control readback", q, {24'h0, v});
    wsel = 4'h0;
    wb(1'b1, CTRL_ADDR, {24'h0, ~v}, q);
    wsel = 4'hf;
    wb(1'b0, CTRL_ADDR, '0, q);
    chk("control kept without select", q, {24'h0, v});
    // Reset in mid-run clears bus outputs, control and status
    nrst <= 1'b0;
    repeat (3) @(posedge clk);
    chk("ack in reset", {31'h0, ack}, 32'h0);
    chk("read data in reset", rdat, 32'h0);
    nrst <= 1'b1;
    wb(1'b0, STAT_ADDR, '0, q);
    chk("status after second reset", q, 32'h0);
    wb(1'b0, CTRL_ADDR, '0, q);
    chk("control after second reset", q, 32'h0);
    test_done();
  end
endmodule : timer3_capture_readout_tb
